//--- include/ubt_pkg.sv
// Purpose: shared constants and types for the upstream burst timing reconfiguration block
// Assumes: 250 MHz pclk, APB slave with 32-bit data
// Notes: offsets are byte addresses of aligned words
package ubt_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned GAP_SHORT_US = 5;
  localparam int unsigned GAP_LONG_US = 10;
  localparam int unsigned GAP_CHAN_MS = 100;
  localparam int unsigned GAP_SHORT_CYC = GAP_SHORT_US * CLK_MHZ;
  localparam int unsigned GAP_LONG_CYC = GAP_LONG_US * CLK_MHZ;
  localparam int unsigned GAP_CHAN_CYC = GAP_CHAN_MS * 1000 * CLK_MHZ;
  localparam int unsigned GAP_SYMBOLS = 96;
  localparam logic [7:0] SMALL_STEP_QDB = 8'h04; // 1 dB in 0.25 dB steps
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_ADJ_INT = 12'h008;
  localparam logic [11:0] OFS_ADJ_FRAC = 12'h00c;
  localparam logic [11:0] OFS_RNG_INT = 12'h010;
  localparam logic [11:0] OFS_RNG_FRAC = 12'h014;
  localparam logic [11:0] OFS_SYM_CYC = 12'h018;
  localparam logic [11:0] OFS_PEND = 12'h01c;
  localparam logic [11:0] OFS_POWER = 12'h020;
  // control bit positions
  localparam int unsigned CTRL_SCDMA = 0;
  localparam int unsigned CTRL_ENABLE = 1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0002;
  localparam logic [15:0] SYM_CYC_RST = 16'h0031; // about 5.12 Msym/s
  // pending change kinds
  localparam int unsigned PEND_POWER = 0;
  localparam int unsigned PEND_RATE = 1;
  localparam int unsigned PEND_OFFS = 2;
  localparam int unsigned PEND_CHAN = 3;
  localparam int unsigned PEND_RNG = 4;
  localparam int unsigned PEND_MOD = 5;
  localparam int unsigned PEND_W = 6;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic signed [31:0] int_part;
    logic [7:0] frac_part;
  } ubt_adj_s;
  typedef struct packed {
    logic [PEND_W-1:0] kind;
    logic big_power;
  } ubt_req_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BURST = 2'b01,
    ST_GAP = 2'b10,
    ST_APPLY = 2'b11
  } ubt_state_e;
endpackage

//--- sim/testbench.sv
// Purpose: self-checking bench for ubt_timing_reconfig
// Assumes: 4 ns pclk, one pclk per symbol after setup
// Notes: channel gap shortened to 200 cycles
`timescale 1ns/1ps
module testbench
  import ubt_pkg::*;
();
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic grant = 1'b0, e, gs;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, q, prdata;
  logic [15:0] min_gap = 16'h0;
  logic pready, pslverr, burst_start, burst_end, apply_pulse, power_settling, gap_short;
  logic [PEND_W-1:0] apply_kind;
  logic signed [31:0] rng_int;
  logic [7:0] rng_frac, power_qdb;
  int err_count = 0, compares = 0, n, napp = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (apply_pulse === 1'b1) napp++;
  ubt_timing_reconfig #(.CHAN_CYC(200)) ubt_timing_reconfig_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .burst_start(burst_start), .burst_end(burst_end), .apply_pulse(apply_pulse),
    .apply_kind(apply_kind), .rng_int(rng_int), .rng_frac(rng_frac), .power_qdb(power_qdb),
    .power_settling(power_settling), .gap_short(gap_short));
  ubt_headend_model ubt_headend_model_i (.pclk(pclk), .presetn(presetn), .grant(grant),
    .min_gap(min_gap), .burst_start(burst_start), .burst_end(burst_end));
  // ----------------
  // shared tasks
  // ----------------
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask
  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one burst; gs notes any short-gap flag seen during it
  task automatic burst(input logic [15:0] g);
    gs = 1'b0;
    @(posedge pclk);
    min_gap <= g;
    grant <= 1'b1;
    do @(posedge pclk); while (burst_start !== 1'b1);
    grant <= 1'b0;
    do begin @(posedge pclk); gs = gs | gap_short; end while (burst_end !== 1'b1);
  endtask
  // post a setting as a burst starts; a post in a long idle gap applies at once
  task automatic post_burst(input logic [11:0] a, input logic [31:0] d, input logic [15:0] g);
    fork
      apb(1'b1, a, d);
      burst(g);
    join
  endtask
  task automatic wait_apply(input string s, input int lo, input int hi, input logic [5:0] k);
    n = 0;
    do begin @(posedge pclk); n++; end while (apply_pulse !== 1'b1 && n < 4000);
    chk(s, 32'h1, n >= lo && n <= hi);
    chk("apply_kind", k, apply_kind);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl reset", CTRL_RST, q);
    apb(1'b0, OFS_SYM_CYC, 32'h0);
    chk("sym_cyc reset", {16'h0, SYM_CYC_RST}, q);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped err", 32'h1, e);
    apb(1'b1, OFS_RNG_INT, 32'h55);
    apb(1'b0, OFS_RNG_INT, 32'h0);
    chk("rng read only", 32'h0, q);
    apb(1'b1, OFS_SYM_CYC, 32'h1);
  endtask
  // adjusts stand for corrections from good bursts only
  task automatic t_rng();
    apb(1'b1, OFS_ADJ_INT, 32'hffff_fffb);
    apb(1'b1, OFS_ADJ_FRAC, 32'h33);
    burst(16'h0);
    wait_apply("rng gap", 96, 100, 6'h10);
    @(posedge pclk);
    chk("rng_int", 32'hffff_fffb, rng_int);
    chk("rng_frac tdma", 32'h0, rng_frac);
    apb(1'b1, OFS_CTRL, 32'h3);
    apb(1'b1, OFS_ADJ_INT, 32'h7);
    post_burst(OFS_ADJ_FRAC, 32'h40, 16'h0);
    wait_apply("rng gap", 96, 100, 6'h10);
    @(posedge pclk);
    chk("rng_int sum", 32'h2, rng_int);
    chk("rng_frac scdma", 32'h40, rng_frac);
  endtask
  task automatic t_kinds();
    int need;
    for (int k = 1; k < 6; k++) begin
      if (k == 4) continue;
      need = k == 5 ? 1 : 96 + (k == 3 ? 200 : 0);
      post_burst(OFS_PEND, 32'h1 << k, 16'h0);
      wait_apply("kind gap", need, need + 4, 6'h1 << k);
    end
  endtask
  task automatic t_short();
    post_burst(OFS_PEND, 32'h4, 16'h0);
    n = napp;
    burst(16'h14);
    chk("gap_short", 32'h1, gs);
    chk("no early apply", n, napp);
    wait_apply("retry gap", 96, 100, 6'h4);
  endtask
  task automatic t_power();
    post_burst(OFS_POWER, 32'h2, 16'h0);
    wait_apply("small power gap", 1346, 1350, 6'h1);
    @(posedge pclk);
    chk("power small", 32'h2, power_qdb);
    chk("settling", 32'h1, power_settling);
    post_burst(OFS_POWER, 32'h10, 16'h0);
    wait_apply("large power gap", 2596, 2600, 6'h1);
    @(posedge pclk);
    chk("power large", 32'h10, power_qdb);
    n = 0;
    while (power_settling === 1'b1 && n < 5000) begin @(posedge pclk); n++; end
    chk("settle len", 32'h1, n <= GAP_LONG_CYC && n > GAP_SHORT_CYC);
  endtask
  task automatic t_fifo();
    int nb;
    int na;
    // applies held off while the fifo fills
    apb(1'b1, OFS_CTRL, 32'h0);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, OFS_ADJ_INT, 32'h1);
      if (i < 8) apb(1'b1, OFS_ADJ_FRAC, 32'h0);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("fifo full", 32'h1, q[2]);
    post_burst(OFS_CTRL, 32'h2, 16'h0);
    nb = napp;
    apb(1'b1, OFS_ADJ_FRAC, 32'h0);
    na = napp;
    chk("write held till pop", nb + 1, na);
    // a nonempty fifo keeps ranging pending, so the rest drains in this gap
    for (int i = 0; i < 8; i++) begin
      wait_apply("drain spacing", 1, 3, 6'h10);
    end
    @(posedge pclk);
    chk("rng drained sum", 32'hb, rng_int);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("fifo empty", 32'h0, q[5]);
  endtask
  task automatic complete_run();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog far beyond the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    complete_run();
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rng();
    t_kinds();
    t_short();
    t_power();
    t_fifo();
    complete_run();
  end
endmodule

//--- sim/ubt_headend_model.sv
// Purpose: headend scheduler stand-in issuing bursts
// Assumes: grant held until burst_start, eight cycle bursts
// Notes: a short min_gap breaks the gap rules on purpose
`timescale 1ns/1ps
module ubt_headend_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // schedule request
  input wire logic grant,
  input wire logic [15:0] min_gap,
  // burst events
  output logic burst_start,
  output logic burst_end
);
  logic [15:0] gap_r;
  logic [3:0] len_r;
  // new burst only once the scheduled gap has run out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 16'hffff;
      len_r <= 4'h0;
      burst_start <= 1'b0;
      burst_end <= 1'b0;
    end else begin
      burst_start <= 1'b0;
      burst_end <= 1'b0;
      if (gap_r != 16'hffff) gap_r <= gap_r + 16'h1;
      if (len_r != 4'h0) begin
        len_r <= len_r - 4'h1;
        burst_end <= len_r == 4'h1;
        if (len_r == 4'h1) gap_r <= 16'h0;
      end else if (grant && gap_r >= min_gap) begin
        burst_start <= 1'b1;
        len_r <= 4'h8;
      end
    end
  end
endmodule

//--- sim/ubt_monitor.sv
// Purpose: port checker for ubt_timing_reconfig
// Assumes: one clock, async active low reset
// Notes: gap bounds assume one pclk per symbol at least
`timescale 1ns/1ps
module ubt_monitor
  import ubt_pkg::*;
(
  // clock, reset and apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // burst events and settings
  input wire logic burst_start,
  input wire logic burst_end,
  input wire logic apply_pulse,
  input wire logic [PEND_W-1:0] apply_kind,
  input wire logic signed [31:0] rng_int,
  input wire logic [7:0] power_qdb,
  input wire logic power_settling
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned gcnt_r;
  int unsigned scnt_r;
  logic inb_r;
  logic bad;
  // gap since burst end, in-burst flag, settle length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gcnt_r <= 0;
      scnt_r <= 0;
      inb_r <= 1'b0;
    end else begin
      gcnt_r <= burst_end ? 0 : (gcnt_r < 99999 ? gcnt_r + 1 : gcnt_r);
      scnt_r <= power_settling ? scnt_r + 1 : 0;
      inb_r <= burst_start | (inb_r & ~burst_end);
    end
  end
  assign bad = paddr > OFS_POWER || paddr[1:0] != 2'b00;
  sequence s_pulse;
    apply_pulse ##1 !apply_pulse;
  endsequence
  a_pulse_single:
    assert property (apply_pulse |-> s_pulse) else $error("apply pulse too long");
  a_unmapped_err:
    assert property (psel && penable && bad |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_rng_at_apply:
    assert property ($changed(rng_int) |-> $past(apply_pulse) && $past(apply_kind[PEND_RNG]))
    else $error("ranging offset moved outside apply");
  a_power_at_apply:
    assert property ($changed(power_qdb) |-> $past(apply_pulse) && $past(apply_kind[PEND_POWER]))
    else $error("power moved outside apply");
  a_no_apply_burst:
    assert property (apply_pulse |-> !inb_r) else $error("apply inside a burst");
  a_rng_gap:
    assert property (apply_pulse && apply_kind[PEND_RNG] |-> gcnt_r >= GAP_SYMBOLS)
    else $error("ranging applied in short gap");
  a_power_gap:
    assert property (apply_pulse && apply_kind[PEND_POWER] |->
                     gcnt_r >= GAP_SYMBOLS + GAP_SHORT_CYC)
    else $error("power applied in short gap");
  a_settle_bound:
    assert property (scnt_r <= GAP_LONG_CYC) else $error("power settling too long");
endmodule
bind ubt_timing_reconfig ubt_monitor ubt_monitor_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .burst_start(burst_start), .burst_end(burst_end),
  .apply_pulse(apply_pulse), .apply_kind(apply_kind), .rng_int(rng_int),
  .power_qdb(power_qdb), .power_settling(power_settling));

//--- src/ubt_fifo.sv
// Purpose: small flop fifo holding timing-adjust words
// Assumes: single clock, push and pop by valid and ready
// Notes: depth must be a power of two
`timescale 1ns/1ps
module ubt_fifo #(
  parameter int unsigned WIDTH = 40,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_r[rp_r[AW-1:0]];

  // pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end

  // storage, no reset needed on data
  always_ff @(posedge pclk) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data;
  end
endmodule

//--- src/ubt_timing_reconfig.sv
// Purpose: ranging offset accumulation and reconfiguration gap enforcement
// Assumes: transmit pipeline reports burst start and end, apb master on pclk
// Notes: the gate pulse is the only moment new settings reach the transmitter
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps

module ubt_timing_reconfig
  import ubt_pkg::*;
#(
  parameter int unsigned CHAN_CYC = GAP_CHAN_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmitter burst events, same clock
  input wire logic burst_start,
  input wire logic burst_end,
  // settings handed to the transmitter
  output logic apply_pulse,
  output logic [PEND_W-1:0] apply_kind,
  output logic signed [31:0] rng_int,
  output logic [7:0] rng_frac,
  output logic [7:0] power_qdb,
  output logic power_settling,
  output logic gap_short
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] sym_cyc_r;
  logic signed [31:0] adj_int_r;
  logic [PEND_W-1:0] pend_r;
  logic big_power_r;
  logic [7:0] power_tgt_r;
  logic [7:0] power_r;
  logic signed [31:0] rng_int_r;
  logic [7:0] rng_frac_r;
  logic [PEND_W-1:0] apply_kind_r;
  logic apply_r;
  logic [31:0] gap_cnt_r;
  logic [31:0] settle_cnt_r;
  logic short_r;
  logic [31:0] prdata_r;
  ubt_state_e state_r;
  ubt_state_e state_nxt;
  logic wr_en;
  logic rd_en;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  ubt_adj_s fifo_in;
  ubt_adj_s fifo_out;
  logic [31:0] need_cyc;
  logic gap_ok;
  logic addr_ok;
  logic [7:0] pdiff;
  logic [PEND_W-1:0] pend_set;
  logic [PEND_W-1:0] pend_clr;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  function automatic logic known(input logic [11:0] a);
    known = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ADJ_INT) ||
            (a == OFS_ADJ_FRAC) || (a == OFS_RNG_INT) || (a == OFS_RNG_FRAC) ||
            (a == OFS_SYM_CYC) || (a == OFS_PEND) || (a == OFS_POWER);
  endfunction

  // writing the fraction word pushes an adjust; stall while the fifo is full
  assign addr_ok = known(paddr);
  assign pready = !(psel && pwrite && (paddr == OFS_ADJ_FRAC) && !fifo_in_ready);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pready && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign prdata = prdata_r;

  // control, symbol period and adjust staging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      sym_cyc_r <= SYM_CYC_RST;
      adj_int_r <= '0;
      power_tgt_r <= '0;
    end else if (wr_en) begin
      case (paddr)
        OFS_CTRL: ctrl_r <= pwdata & 32'h0000_0003;
        OFS_SYM_CYC: sym_cyc_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
        OFS_ADJ_INT: adj_int_r <= pwdata;
        OFS_POWER: power_tgt_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // adjust word enters the fifo on the fraction write
  assign fifo_in.int_part = adj_int_r;
  // tdma ignores the fraction field
  assign fifo_in.frac_part = ctrl_r[CTRL_SCDMA] ? pwdata[7:0] : 8'h00;
  assign fifo_in_valid = wr_en && (paddr == OFS_ADJ_FRAC);

  ubt_fifo #(
    .WIDTH(40),
    .DEPTH(8)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out)
  );

  // read data captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (rd_en) begin
      case (paddr)
        OFS_CTRL: prdata_r <= ctrl_r;
        OFS_STATUS: prdata_r <= {26'h0, fifo_out_valid, power_settling, short_r,
                                 !fifo_in_ready, state_r};
        OFS_ADJ_INT: prdata_r <= adj_int_r;
        OFS_RNG_INT: prdata_r <= rng_int_r;
        OFS_RNG_FRAC: prdata_r <= {24'h0, rng_frac_r};
        OFS_SYM_CYC: prdata_r <= {16'h0, sym_cyc_r};
        OFS_PEND: prdata_r <= {25'h0, big_power_r, pend_r};
        OFS_POWER: prdata_r <= {16'h0, power_r, power_tgt_r};
        default: prdata_r <= '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pending changes
  // ---------------------------------------------------------------
  assign pdiff = (power_tgt_r >= power_r) ? power_tgt_r - power_r : power_r - power_tgt_r;

  // kinds applied this cycle are cleared, only freshly posted ones survive
  assign pend_clr = apply_r ? apply_kind_r : '0;

  // posts from software; a queued word keeps ranging pending, not in its pop cycle
  always_comb begin
    pend_set = '0;
    if (wr_en && paddr == OFS_PEND) pend_set = pwdata[PEND_W-1:0];
    if (wr_en && paddr == OFS_POWER) pend_set[PEND_POWER] = 1'b1;
    if (fifo_out_valid && !fifo_out_ready) pend_set[PEND_RNG] = 1'b1;
  end

  // software posts kinds, hardware clears at apply; a new post wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= '0;
      big_power_r <= 1'b0;
    end else begin
      pend_r <= (pend_r & ~pend_clr) | pend_set;
      if (wr_en && paddr == OFS_POWER) big_power_r <= 1'b0;
      // power step size picks the gap
      if (pend_r[PEND_POWER] && pdiff > SMALL_STEP_QDB) big_power_r <= 1'b1;
    end
  end

  // required gap: 96 symbols, plus the channel gap if a channel change is pending, else the power step's gap
  always_comb begin
    need_cyc = 32'(GAP_SYMBOLS) * {16'h0, sym_cyc_r};
    if (pend_r[PEND_CHAN]) need_cyc = need_cyc + 32'(CHAN_CYC);
    else if (pend_r[PEND_POWER] && big_power_r) need_cyc = need_cyc + 32'(GAP_LONG_CYC);
    else if (pend_r[PEND_POWER]) need_cyc = need_cyc + 32'(GAP_SHORT_CYC);
    // modulation alone rides the guard time
    if (pend_r == (PEND_W'(1) << PEND_MOD)) need_cyc = 32'h0000_0001;
  end

  // ---------------------------------------------------------------
  // burst and gap state machine
  // ---------------------------------------------------------------
  assign gap_ok = (gap_cnt_r >= need_cyc);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (burst_start) state_nxt = ST_BURST;
      ST_BURST: if (burst_end) state_nxt = ST_GAP;
      // settings move only after the previous burst's energy is gone
      ST_GAP: begin
        if (burst_start) state_nxt = ST_BURST;
        else if (pend_r != '0 && gap_ok && ctrl_r[CTRL_ENABLE]) state_nxt = ST_APPLY;
      end
      ST_APPLY: state_nxt = burst_start ? ST_BURST : ST_GAP;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // gap length counter since last burst end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_cnt_r <= '0;
    else if (burst_end || burst_start) gap_cnt_r <= '0;
    else if (gap_cnt_r != 32'hffff_ffff) gap_cnt_r <= gap_cnt_r + 1'b1;
  end

  // grant shorter than needed at next burst start is flagged, changes wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) short_r <= 1'b0;
    else if (burst_start) short_r <= (state_r == ST_GAP) && (pend_r != '0) && !gap_ok;
  end

  // ---------------------------------------------------------------
  // apply: ranging accumulate, power, other kinds
  // ---------------------------------------------------------------
  assign fifo_out_ready = apply_r && apply_kind_r[PEND_RNG];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apply_r <= 1'b0;
      apply_kind_r <= '0;
    end else begin
      apply_r <= (state_nxt == ST_APPLY) && (state_r == ST_GAP);
      if ((state_nxt == ST_APPLY) && (state_r == ST_GAP)) apply_kind_r <= pend_r;
    end
  end

  // signed add, negative delays transmission; fraction carries into integer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rng_int_r <= '0;
      rng_frac_r <= '0;
    end else if (fifo_out_ready && fifo_out_valid) begin
      {rng_int_r, rng_frac_r} <= 40'({rng_int_r, rng_frac_r} +
                                     {fifo_out.int_part, fifo_out.frac_part});
    end
  end

  // power steps at apply; settle window tracks the deadline
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_r <= '0;
      settle_cnt_r <= '0;
    end else if (apply_r && apply_kind_r[PEND_POWER]) begin
      power_r <= power_tgt_r;
      settle_cnt_r <= big_power_r ? 32'(GAP_LONG_CYC) : 32'(GAP_SHORT_CYC);
    end else if (settle_cnt_r != '0) begin
      settle_cnt_r <= settle_cnt_r - 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // offset kept at full fraction precision, finer than any symbol
  assign rng_int = rng_int_r;
  assign rng_frac = rng_frac_r;
  assign power_qdb = power_r;
  assign power_settling = (settle_cnt_r != '0);
  assign apply_pulse = apply_r;
  assign apply_kind = apply_kind_r;
  assign gap_short = short_r;
endmodule
